/* File: design/ctm_pkg.sv */
`default_nettype none
package ctm_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses, 32-bit words)
  // ------------------------------------------------------------
  localparam logic [15:0] CTM_ADDR_TRIG_MODE   = 16'h0830;
  localparam logic [15:0] CTM_ADDR_SHUTTER     = 16'h081C;
  localparam logic [15:0] CTM_ADDR_FRAME_TIME  = 16'h0840;
  localparam logic [15:0] CTM_ADDR_SW_TRIG     = 16'h102C;
  localparam logic [15:0] CTM_ADDR_PIN_FIRST   = 16'h1100;
  localparam logic [15:0] CTM_ADDR_PIN_LAST    = 16'h1144;
  localparam logic [15:0] CTM_ADDR_STATUS      = 16'h0844;
  // ------------------------------------------------------------
  // trigger configuration fields (bit 0 = lsb)
  // ------------------------------------------------------------
  localparam int          CTM_TM_ENABLE_BIT    = 25;
  localparam int          CTM_TM_POLARITY_BIT  = 24;
  localparam int          CTM_TM_MODE_LSB      = 16;
  localparam int          CTM_TM_MODE_W        = 4;
  localparam int          CTM_TM_PARAM_LSB     = 0;
  localparam int          CTM_TM_PARAM_W       = 12;
  localparam logic [3:0]  CTM_MODE_EDGE        = 4'h0;
  localparam logic [3:0]  CTM_MODE_LEVEL       = 4'h1;
  localparam logic [3:0]  CTM_MODE_SKIP        = 4'h3;
  // ------------------------------------------------------------
  // pin configuration fields and resets
  // ------------------------------------------------------------
  localparam int          CTM_PIN_COUNT        = 18;
  localparam int          CTM_PIN_SEL_W        = 2;
  localparam int          CTM_PIN_TRIG_EN_BIT  = 0;
  localparam logic [31:0] CTM_TRIG_MODE_RST    = 32'h0000_0001;
  localparam logic [31:0] CTM_SHUTTER_RST      = 32'h0000_0064;
  localparam logic [31:0] CTM_FRAME_TIME_RST   = 32'h0000_03E8;
  localparam logic [31:0] CTM_PIN_RST          = 32'h0000_0000;
  localparam logic [31:0] CTM_RD_ZERO          = 32'h0000_0000;
  // ------------------------------------------------------------
  // timing: exposure and frame settings are counted in microseconds
  // ------------------------------------------------------------
  localparam int          CTM_CLK_HZ           = 10_000_000;
  localparam int          CTM_TICK_NS          = 1000;
  localparam int          CTM_TICK_CYC         = CTM_TICK_NS / (1_000_000_000 / CTM_CLK_HZ);
endpackage : ctm_pkg
`default_nettype wire

/* File: design/ctm_pin_sync.sv */
`default_nettype none
module ctm_pin_sync
  import ctm_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  // ------------------------------------------------------------
  // two-stage synchroniser per bit
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          meta_r[g] <= 1'b1;
          o_sync[g] <= 1'b1;
        end else begin
          meta_r[g] <= i_async[g];
          o_sync[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule : ctm_pin_sync
`default_nettype wire

/* File: design/ctm_trigger.sv */
// Chosen here: the plain strobed port and the register offsets.
`default_nettype none
module ctm_trigger
  import ctm_pkg::*;
#(
  parameter int NPIN = CTM_PIN_COUNT
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic [15:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [NPIN-1:0] i_gpio,
  output logic             o_expose,
  output logic             o_frame_start,
  output logic             o_frame_send
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0]       trig_mode_r;
  logic [31:0]       shutter_r;
  logic [31:0]       frame_time_r;
  logic [31:0]       pin_cfg_r [NPIN];
  logic [NPIN-1:0]   gpio_s;
  logic              trig_lvl_r;
  logic              sw_trig_r;
  logic [31:0]       exp_cnt_r;
  logic [31:0]       tick_cnt_r;
  logic [31:0]       frame_cnt_r;
  logic [11:0]       skip_cnt_r;
  logic              expose_nxt;
  logic              tick;
  logic              trig_lvl;
  logic              rise;
  logic              fall;
  logic              edge_hit;
  logic              exp_start;
  logic              frame_evt;
  logic [3:0]        mode;
  logic [11:0]       skip_n;
  logic              trig_en;
  logic              pol_rise;
  logic              pin_hit;
  logic [5:0]        pin_idx;

  typedef enum logic [1:0] {ST_IDLE, ST_TIMED, ST_BULB} ctm_state_type;
  ctm_state_type state_r;

  assign mode     = trig_mode_r[CTM_TM_MODE_LSB +: CTM_TM_MODE_W];
  assign skip_n   = trig_mode_r[CTM_TM_PARAM_LSB +: CTM_TM_PARAM_W];
  assign trig_en  = trig_mode_r[CTM_TM_ENABLE_BIT];
  assign pol_rise = trig_mode_r[CTM_TM_POLARITY_BIT];
  assign pin_hit  = (i_addr >= CTM_ADDR_PIN_FIRST) && (i_addr <= CTM_ADDR_PIN_LAST);
  assign pin_idx  = 6'((i_addr - CTM_ADDR_PIN_FIRST) >> 2);

  ctm_pin_sync #(.W(NPIN)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_gpio),
    .o_sync    (gpio_s)
  );

  // ------------------------------------------------------------
  // trigger source: pins enabled for trigger, anded (idle high)
  // ------------------------------------------------------------
  always_comb begin
    trig_lvl = 1'b1;
    for (int k = 0; k < NPIN; k++) begin
      if (pin_cfg_r[k][CTM_PIN_TRIG_EN_BIT]) begin
        trig_lvl = trig_lvl & gpio_s[k];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trig_lvl_r <= 1'b1;
    end else begin
      trig_lvl_r <= trig_lvl;
    end
  end

  assign fall     = trig_lvl_r & ~trig_lvl;
  assign rise     = ~trig_lvl_r & trig_lvl;
  // software trigger acts as an edge in edge mode only; bulb needs a real level
  assign edge_hit = (pol_rise ? rise : fall) | sw_trig_r;

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trig_mode_r  <= CTM_TRIG_MODE_RST;
      shutter_r    <= CTM_SHUTTER_RST;
      frame_time_r <= CTM_FRAME_TIME_RST;
    end else if (i_wr) begin
      if (i_addr == CTM_ADDR_TRIG_MODE) begin
        trig_mode_r <= i_wdata;
      end
      if (i_addr == CTM_ADDR_SHUTTER) begin
        shutter_r <= i_wdata;
      end
      if (i_addr == CTM_ADDR_FRAME_TIME) begin
        frame_time_r <= i_wdata;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          pin_cfg_r[g] <= CTM_PIN_RST;
        end else if (i_wr && pin_hit && pin_idx == 6'(g)) begin
          pin_cfg_r[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // write of bit 31 fires one software trigger
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sw_trig_r <= 1'b0;
    end else begin
      sw_trig_r <= i_wr && i_addr == CTM_ADDR_SW_TRIG && i_wdata[31];
    end
  end

  // ------------------------------------------------------------
  // microsecond tick and free-running frame clock
  // ------------------------------------------------------------
  assign tick = (tick_cnt_r == 32'(CTM_TICK_CYC - 1));

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  // current frame period, not the fastest one
  assign frame_evt = tick && (frame_cnt_r + 32'h0000_0001 >= frame_time_r);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_cnt_r <= 32'h0000_0000;
    end else if (tick) begin
      frame_cnt_r <= frame_evt ? 32'h0000_0000 : frame_cnt_r + 32'h0000_0001;
    end
  end

  // skip counter: one internal trigger every N frame periods
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      skip_cnt_r <= 12'h000;
    end else if (!(trig_en && mode == CTM_MODE_SKIP)) begin
      skip_cnt_r <= 12'h000;
    end else if (frame_evt) begin
      skip_cnt_r <= (skip_cnt_r + 12'h001 >= skip_n) ? 12'h000 : skip_cnt_r + 12'h001;
    end
  end

  // ------------------------------------------------------------
  // exposure start selection
  // ------------------------------------------------------------
  always_comb begin
    exp_start = 1'b0;
    if (!trig_en) begin
      exp_start = frame_evt;
    end else if (mode == CTM_MODE_EDGE) begin
      exp_start = edge_hit;
    end else if (mode == CTM_MODE_LEVEL) begin
      exp_start = fall;
    end else if (mode == CTM_MODE_SKIP) begin
      exp_start = frame_evt && skip_cnt_r == 12'h000;
    end
  end

  // ------------------------------------------------------------
  // exposure state machine
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r   <= ST_IDLE;
      exp_cnt_r <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (exp_start) begin
            if (trig_en && mode == CTM_MODE_LEVEL) begin
              state_r <= ST_BULB;
            end else begin
              state_r   <= ST_TIMED;
              // counted in clocks so the length does not depend on the tick phase
              exp_cnt_r <= 32'(shutter_r * CTM_TICK_CYC);
            end
          end
        end
        ST_TIMED: begin
          // shutter of zero still yields a one-clock exposure
          if (exp_cnt_r <= 32'h0000_0001) begin
            state_r <= ST_IDLE;
          end else begin
            exp_cnt_r <= exp_cnt_r - 32'h0000_0001;
          end
        end
        ST_BULB: begin
          if (rise) state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // exposure level one clock ahead, so it rises with frame start
  // ------------------------------------------------------------
  always_comb begin
    expose_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        expose_nxt = exp_start;
      end
      ST_TIMED: begin
        expose_nxt = (exp_cnt_r > 32'h0000_0001);
      end
      ST_BULB: begin
        expose_nxt = !rise;
      end
      default: begin
        expose_nxt = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // outputs, all registered
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_expose      <= 1'b0;
      o_frame_start <= 1'b0;
      o_frame_send  <= 1'b0;
    end else begin
      o_expose      <= expose_nxt;
      o_frame_start <= exp_start && state_r == ST_IDLE;
      o_frame_send  <= exp_start && state_r == ST_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= CTM_RD_ZERO;
    end else if (i_rd) begin
      if (i_addr == CTM_ADDR_TRIG_MODE) begin
        o_rdata <= trig_mode_r;
      end else if (i_addr == CTM_ADDR_SHUTTER) begin
        o_rdata <= shutter_r;
      end else if (i_addr == CTM_ADDR_FRAME_TIME) begin
        o_rdata <= frame_time_r;
      end else if (i_addr == CTM_ADDR_STATUS) begin
        o_rdata <= {29'h0, trig_lvl_r, state_r};
      end else if (pin_hit && pin_idx < 6'(NPIN)) begin
        // pin words past the last existing pin read as zero
        o_rdata <= pin_cfg_r[pin_idx[4:0]];
      end else begin
        o_rdata <= CTM_RD_ZERO;
      end
    end else begin
      o_rdata <= CTM_RD_ZERO;
    end
  end
endmodule : ctm_trigger
`default_nettype wire

/* File: bench/ctm_trigger_asserts.sv */
`default_nettype none
module ctm_trigger_checker
  import ctm_pkg::*;
#(
  parameter int NPIN = CTM_PIN_COUNT
) (
  input wire logic            i_sys_clk,
  input wire logic            i_rstn,
  input wire logic [15:0]     i_addr,
  input wire logic [31:0]     i_wdata,
  input wire logic            i_wr,
  input wire logic            i_rd,
  input wire logic [31:0]     o_rdata,
  input wire logic [NPIN-1:0] i_gpio,
  input wire logic            o_expose,
  input wire logic            o_frame_start,
  input wire logic            o_frame_send
);
  // ----
  // shadow of the settings, taken from the write port
  // ----
  logic [31:0] mode_r, shut_r, fper_r;
  logic        pin_r, gap_ok_r, lvl;
  int          len_r, gap_r, lo_r, held_r;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  assign lvl = mode_r[CTM_TM_ENABLE_BIT] && mode_r[19:16] == CTM_MODE_LEVEL && pin_r;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r <= CTM_TRIG_MODE_RST;
      shut_r <= CTM_SHUTTER_RST;
      fper_r <= CTM_FRAME_TIME_RST;
      pin_r  <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == CTM_ADDR_TRIG_MODE) mode_r <= i_wdata;
      if (i_addr == CTM_ADDR_SHUTTER) shut_r <= i_wdata;
      if (i_addr == CTM_ADDR_FRAME_TIME) fper_r <= i_wdata;
      if (i_addr == CTM_ADDR_PIN_FIRST) pin_r <= i_wdata[CTM_PIN_TRIG_EN_BIT];
    end
  end
  // a write may restart the internal timer, so the next gap is not judged
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      len_r    <= 0;
      gap_r    <= 0;
      lo_r     <= 0;
      held_r   <= 0;
      gap_ok_r <= 1'b0;
    end else begin
      len_r <= o_frame_start ? 1 : len_r + int'(o_expose);
      gap_r <= o_frame_start ? 1 : gap_r + 1;
      lo_r  <= i_gpio[0] ? 0 : lo_r + 1;
      if (i_gpio[0] && lo_r != 0) held_r <= lo_r;
      if (i_wr) gap_ok_r <= 1'b0;
      else if (o_frame_start) gap_ok_r <= 1'b1;
    end
  end
  sequence s_pin_fall;
    lvl && $fell(i_gpio[0]) && !o_expose;
  endsequence
  sequence s_expose_end;
    $fell(o_expose);
  endsequence
  AST_SEND_EQ_START: assert property (o_frame_send == o_frame_start)
    else $error("frame send differs from frame start");
  AST_START_ONE_CYCLE: assert property (o_frame_start |=> !o_frame_start)
    else $error("frame start longer than one cycle");
  AST_START_OPENS: assert property (o_frame_start == $rose(o_expose))
    else $error("exposure rise without frame start");
  AST_RDATA_QUIET: assert property (!i_rd |=> o_rdata == CTM_RD_ZERO)
    else $error("read data outside read cycle");
  AST_LVL_START: assert property (s_pin_fall |-> ##[2:5] o_frame_start)
    else $error("level mode start missing");
  AST_LVL_LEN: assert property (s_expose_end ##0 mode_r[19:16] == CTM_MODE_LEVEL |-> len_r == held_r)
    else $error("level exposure differs from low time");
  AST_EXPOSE_LEN: assert property (s_expose_end ##0 mode_r[19:16] != CTM_MODE_LEVEL
    |-> len_r == shut_r * CTM_TICK_CYC)
    else $error("exposure length differs from shutter");
  AST_SKIP_PERIOD: assert property (o_frame_start && gap_ok_r
    && (!mode_r[CTM_TM_ENABLE_BIT] || mode_r[19:16] == CTM_MODE_SKIP)
    |-> gap_r == ((mode_r[CTM_TM_ENABLE_BIT] && mode_r[11:0] > 1) ? mode_r[11:0] : 1) * fper_r * CTM_TICK_CYC)
    else $error("internal trigger period wrong");
endmodule : ctm_trigger_checker
bind ctm_trigger ctm_trigger_checker #(.NPIN(NPIN)) i_ctm_trigger_checker (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio(i_gpio), .o_expose(o_expose),
  .o_frame_start(o_frame_start), .o_frame_send(o_frame_send));
`default_nettype wire

/* File: bench/ctm_trig_source.sv */
`default_nettype none
module ctm_trig_source #(
  parameter int NPIN = 18
) (
  input  wire logic            i_sys_clk,
  output logic      [NPIN-1:0] o_gpio
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins are pulled up, so a quiet source reads high
  initial o_gpio = '1;
  task automatic hold_low(input int n);
    @(posedge i_sys_clk);
    o_gpio[0] <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
    o_gpio[0] <= 1'b1;
  endtask : hold_low
endmodule : ctm_trig_source
`default_nettype wire

/* File: bench/test_camera_trigger_modes.sv */
`default_nettype none
module test_camera_trigger_modes
  import ctm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_sys_clk, i_rstn, i_wr, i_rd, o_expose, o_frame_start, o_frame_send;
  logic [15:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [17:0] gpio;
  int          fails, n_checks, w, l;
  ctm_trigger i_ctm_trigger (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio(gpio),
    .o_expose(o_expose), .o_frame_start(o_frame_start), .o_frame_send(o_frame_send));
  ctm_trig_source i_ctm_trig_source (.i_sys_clk(i_sys_clk), .o_gpio(gpio));
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // ----
  // bus tasks and checks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic chk_in(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      fails++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_in
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    @(negedge i_sys_clk);
    chk($sformatf("rdata %0h", a), e, o_rdata);
  endtask : rd
  // timed exposures are never shortened by a write, so wait for quiet first
  task automatic idle;
    for (int k = 0; k < 3000 && o_expose !== 1'b0; k++) @(negedge i_sys_clk);
  endtask : idle
  task automatic grab(input int lim, output int wc, output int lc);
    wc = 0;
    lc = 0;
    do begin
      @(negedge i_sys_clk);
      wc++;
    end while (o_frame_start !== 1'b1 && wc < lim);
    while (o_expose === 1'b1) begin
      @(negedge i_sys_clk);
      lc++;
    end
  endtask : grab
  task automatic summarize;
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    #(100 * 20000);
    fails++;
    summarize();
  end
  initial begin
    {i_rstn, i_wr, i_rd, i_addr, i_wdata, fails, n_checks} = '0;
    repeat (6) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    rd(CTM_ADDR_TRIG_MODE, CTM_TRIG_MODE_RST);
    rd(CTM_ADDR_SHUTTER, CTM_SHUTTER_RST);
    rd(CTM_ADDR_FRAME_TIME, CTM_FRAME_TIME_RST);
    rd(CTM_ADDR_PIN_LAST, CTM_PIN_RST);
    idle();
    wr(CTM_ADDR_TRIG_MODE, 32'h0200_0000);
    wr(CTM_ADDR_SHUTTER, 32'h0000_0002);
    wr(CTM_ADDR_FRAME_TIME, 32'h0000_0003);
    wr(CTM_ADDR_PIN_FIRST, 32'h0000_0001);
    wr(CTM_ADDR_PIN_LAST, 32'h0000_0001);
    wr(16'h1148, 32'hFFFF_FFFF);
    rd(CTM_ADDR_PIN_LAST, 32'h0000_0001);
    rd(16'h1148, CTM_RD_ZERO);
    fork i_ctm_trig_source.hold_low(5); grab(20, w, l); join
    chk_in("fall start", 2, 8, w);
    chk("edge length", 2 * CTM_TICK_CYC, l);
    idle();
    wr(CTM_ADDR_TRIG_MODE, 32'h0300_0000);
    fork i_ctm_trig_source.hold_low(40); grab(80, w, l); join
    chk_in("rise start", 41, 48, w);
    idle();
    wr(CTM_ADDR_SW_TRIG, 32'h8000_0000);
    grab(10, w, l);
    chk_in("soft start", 1, 6, w);
    chk("soft length", 2 * CTM_TICK_CYC, l);
    idle();
    wr(CTM_ADDR_TRIG_MODE, 32'h0201_0000);
    fork i_ctm_trig_source.hold_low(50); grab(20, w, l); join
    chk_in("level start", 2, 8, w);
    chk("level length", 32'd50, l);
    idle();
    wr(CTM_ADDR_TRIG_MODE, 32'h0203_0003);
    rd(CTM_ADDR_TRIG_MODE, 32'h0203_0003);
    grab(200, w, l);
    grab(200, w, l);
    chk("skip period", 3 * 3 * CTM_TICK_CYC, w + l);
    chk("skip length", 2 * CTM_TICK_CYC, l);
    summarize();
  end
endmodule : test_camera_trigger_modes
`default_nettype wire
